/* File: qlc_pkg.sv */
// Shared constants of the quad line control port: address map, fields,
// reset values and frame timing.
// Assumes nothing beyond a SystemVerilog compiler.
package qlc_pkg;

  // Number of line transceivers and bits per serial transfer.
  localparam int NUM_LINES = 4;
  localparam int TRANSFER_BITS = 16;
  localparam logic [4:0] ADDR_DONE_CNT = 5'h07;
  localparam logic [4:0] DATA_START_CNT = 5'h08;
  localparam logic [4:0] LAST_BIT_CNT = 5'h0f;
  localparam logic [4:0] TRANSFER_DONE_CNT = 5'h10;

  // Address of the common status register.
  localparam logic [7:0] ADDR_STATUS = 8'hff;

  // Per-line register select codes in address bits 3..1.
  localparam logic [2:0] SEL_TX_D = 3'h0;
  localparam logic [2:0] SEL_TX_B1 = 3'h1;
  localparam logic [2:0] SEL_TX_B2 = 3'h2;
  localparam logic [2:0] SEL_RX_D = 3'h3;
  localparam logic [2:0] SEL_RX_B1 = 3'h4;
  localparam logic [2:0] SEL_RX_B2 = 3'h5;
  localparam logic [2:0] SEL_UNUSED = 3'h6;
  localparam logic [2:0] SEL_CTRL = 3'h7;

  // Line control register bit positions.
  localparam int CTRL_ACTIVATE = 7;
  localparam int CTRL_DIGITAL_LOOP = 6;
  localparam int CTRL_LINE_LOOP = 5;
  localparam int CTRL_B1_LOOP = 4;
  localparam int CTRL_B2_LOOP = 3;
  localparam int CTRL_INT_ENABLE = 2;
  localparam int CTRL_D_TX_BLOCK = 1;
  localparam int CTRL_D_RX_BLOCK = 0;

  // B slot register layout: channel enable and slot number.
  localparam int SLOT_ENABLE_BIT = 7;
  localparam int SLOT_NUMBER_MSB = 5;

  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SLOT_RESET = 8'h00;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam logic [7:0] FIRST_OUT_BYTE = 8'h00;

  // Frame timing: 125 us frames at a 4.096 MHz bit clock.
  localparam int FRAME_TIME_NS = 125000;
  localparam int BIT_CLOCK_KHZ = 4096;
  localparam int FRAME_BITS = FRAME_TIME_NS * BIT_CLOCK_KHZ / 1000000;
  localparam int BIT_POS_W = 9;

endpackage : qlc_pkg

/* File: qlc_frame_timer.sv */
// Frame and bit position timer of the multiplexed B and D ports.
// Assumes bit_clock and frame_sync are pins, asynchronous to clk.
`timescale 1ns/10ps
module qlc_frame_timer
  import qlc_pkg::*;
#(
  parameter int FRAME_BITS_P = FRAME_BITS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_enable,
  input wire logic bit_clock,
  input wire logic frame_sync,
  output logic bit_tick,
  output logic [BIT_POS_W-1:0] bit_pos
);

  // Two-stage synchronisers; only stage two is looked at.
  logic bclk_meta, bclk_sync, bclk_prev;
  logic fs_meta, fs_sync, fs_at_rise;
  logic bclk_rise;

  // Synchronise both pins and keep the last bit clock level.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bclk_meta <= 1'b0;
      bclk_sync <= 1'b0;
      bclk_prev <= 1'b0;
      fs_meta <= 1'b0;
      fs_sync <= 1'b0;
    end else if (clk_enable) begin
      bclk_meta <= bit_clock;
      bclk_sync <= bclk_meta;
      bclk_prev <= bclk_sync;
      fs_meta <= frame_sync;
      fs_sync <= fs_meta;
    end
  end

  assign bclk_rise = bclk_sync & ~bclk_prev;

  // The first rising bit clock edge after frame sync goes high restarts
  // the count at zero; otherwise the count free-runs and wraps.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_pos <= '0;
      fs_at_rise <= 1'b0;
      bit_tick <= 1'b0;
    end else if (clk_enable) begin
      bit_tick <= bclk_rise;
      if (bclk_rise) begin
        fs_at_rise <= fs_sync;
        if (fs_sync && !fs_at_rise) begin
          bit_pos <= '0;
        end else if (bit_pos == BIT_POS_W'(FRAME_BITS_P - 1)) begin
          bit_pos <= '0;
        end else begin
          bit_pos <= bit_pos + 1'b1;
        end
      end
    end
  end

endmodule : qlc_frame_timer

/* File: qlc_port.sv */
// Serial control port, per-line register set and slot framing of a
// four-line subscriber loop transceiver.
// Assumes line-side logic on clk supplies received channel data and sync
// state, and a host drives serial_clock and select_n.
// Function
// - Each transfer moves two bytes both ways
// - Sample input rising, change output falling
// - Serial output undriven while select high
// - Sync or detect change latches interrupt; status read releases
// - Even address writes, odd only reads
// - Address high nibble selects line 0-3
// - Address bits 3..1 select line register
// - Address FF reads common status register
// - Bytes shift most significant bit first
// - Control registers reset to zero, lines down
// - Activate bit powers line up, keeps registers
// - Bit 5 loops all received channels back
// - Bits 4, 3 loop B1, B2 back
// - Bit 6 returns system data to outputs
// - Bit 2 enables that line's interrupt
// - Bits 1, 0 block D channel paths
// - Sixty-four eight-bit slots per frame
// - D channel uses 2-bit sub-slots
// - Frame starts first bit edge after sync
// - Six slot registers per line
// - Receive slot indicator low during assigned B receive slots of activated lines
// - Two status bits per line; read clears violation
// - B slot: enable bit 7, slot 5..0
`timescale 1ns/10ps
module qlc_port
  import qlc_pkg::*;
#(
  parameter int LINES = NUM_LINES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_enable,
  input wire logic serial_clock,
  input wire logic select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  output logic interrupt_n_out,
  output logic interrupt_oe,
  input wire logic bit_clock,
  input wire logic frame_sync,
  input wire logic b_data_in,
  output logic b_data_out,
  output logic b_data_out_oe,
  input wire logic d_data_in,
  output logic d_data_out,
  output logic d_data_out_oe,
  output logic rx_slot_active_n,
  input wire logic [LINES-1:0] line_signal_detect,
  input wire logic [LINES-1:0] line_in_sync,
  input wire logic [LINES-1:0] line_bipolar_violation,
  input wire logic [LINES*8-1:0] line_rx_b1,
  input wire logic [LINES*8-1:0] line_rx_b2,
  input wire logic [LINES*2-1:0] line_rx_d,
  output logic [LINES-1:0] line_power_up,
  output logic [LINES*8-1:0] line_tx_b1,
  output logic [LINES*8-1:0] line_tx_b2,
  output logic [LINES*2-1:0] line_tx_d
);

  // True when a B slot register is enabled and names the given slot.
  function automatic logic slot_hit(input logic [7:0] r, input logic [5:0] s);
    slot_hit = r[SLOT_ENABLE_BIT] && (r[SLOT_NUMBER_MSB:0] == s);
  endfunction : slot_hit

  // Picks the bit of a byte that goes out at the given bit index.
  function automatic logic pick_bit(input logic [7:0] v, input logic [2:0] i);
    pick_bit = v[3'h7 - i];
  endfunction : pick_bit

  // ---------------- Serial clock domain ----------------

  // Register file owned by the serial domain, indexed by line and select.
  logic [7:0] reg_file [LINES][8];
  // Rising edges counted in this transfer, 0 to 16.
  logic [4:0] bit_cnt;
  // Bits shifted in so far, newest in bit 0.
  logic [14:0] in_shift;
  // Address byte, valid from the eighth rising edge.
  logic [7:0] addr_q;
  // Outgoing byte shift register for the falling edge side.
  logic [7:0] out_shift;
  // Toggles announcing a committed write and a status read start.
  logic write_tgl;
  logic status_rd_tgl;
  // Status byte made on clk, and the copy of it brought over to this side;
  // stage one feeds stage two only.
  logic [7:0] status_q;
  logic [7:0] status_meta;
  logic [7:0] status_sync;
  // Value returned in the data byte.
  logic [7:0] rd_val;
  // Full incoming word at the sixteenth edge, and its address fields.
  logic [15:0] word;
  logic addr_mapped;

  assign word = {in_shift, serial_in};

  // A line register exists only for lines 0-3 and a used select code.
  always_comb begin
    addr_mapped = (word[15:14] == 2'h0) && (word[11:9] != SEL_UNUSED);
  end

  // Count and shift on rising edges. Select high clears the transfer at
  // once, so a short window never reaches the commit edge.
  always_ff @(posedge serial_clock or negedge reset_n or posedge select_n) begin
    if (!reset_n) begin
      bit_cnt <= 5'h00;
      in_shift <= '0;
      addr_q <= 8'h00;
    end else if (select_n) begin
      bit_cnt <= 5'h00;
      in_shift <= '0;
      addr_q <= 8'h00;
    end else if (bit_cnt != TRANSFER_DONE_CNT) begin
      bit_cnt <= bit_cnt + 5'h01;
      in_shift <= word[14:0];
      if (bit_cnt == ADDR_DONE_CNT) begin
        addr_q <= word[7:0];
      end
    end
  end

  // Commit the write on the sixteenth edge. Only even, mapped addresses
  // store; odd addresses and unused space leave the registers alone.
  always_ff @(posedge serial_clock or negedge reset_n) begin
    if (!reset_n) begin
      write_tgl <= 1'b0;
      for (int l = 0; l < LINES; l++) begin
        for (int s = 0; s < 8; s++) begin
          reg_file[l][s] <= (3'(s) == SEL_CTRL) ? CTRL_RESET : SLOT_RESET;
        end
      end
    end else if (!select_n && bit_cnt == LAST_BIT_CNT) begin
      if (!word[8] && addr_mapped) begin
        reg_file[word[13:12]][word[11:9]] <= word[7:0];
        write_tgl <= ~write_tgl;
      end
    end
  end

  // Announce the start of a status read once the address is in, and keep
  // a synchronised copy of the status byte for the readback.
  always_ff @(posedge serial_clock or negedge reset_n) begin
    if (!reset_n) begin
      status_rd_tgl <= 1'b0;
      status_meta <= 8'h00;
      status_sync <= 8'h00;
    end else begin
      status_meta <= status_q;
      status_sync <= status_meta;
      if (!select_n && bit_cnt == ADDR_DONE_CNT && word[7:0] == ADDR_STATUS) begin
        status_rd_tgl <= ~status_rd_tgl;
      end
    end
  end

  // Previous contents of the addressed register, or zero if unmapped.
  always_comb begin
    rd_val = 8'h00;
    if (addr_q == ADDR_STATUS) begin
      rd_val = status_sync;
    end else if (addr_q[7:6] == 2'h0 && addr_q[3:1] != SEL_UNUSED) begin
      rd_val = reg_file[addr_q[5:4]][addr_q[3:1]];
    end
  end

  // Shift out on falling edges: a zero byte during the address, then the
  // readback byte, most significant bit first.
  always_ff @(negedge serial_clock or negedge reset_n or posedge select_n) begin
    if (!reset_n) begin
      serial_out <= 1'b0;
      out_shift <= FIRST_OUT_BYTE;
    end else if (select_n) begin
      serial_out <= FIRST_OUT_BYTE[7];
      out_shift <= FIRST_OUT_BYTE;
    end else if (bit_cnt == DATA_START_CNT) begin
      serial_out <= rd_val[7];
      out_shift <= {rd_val[6:0], 1'b0};
    end else begin
      serial_out <= out_shift[7];
      out_shift <= {out_shift[6:0], 1'b0};
    end
  end

  // The return line is driven only while selected, so several ports can
  // share it.
  assign serial_out_oe = reset_n & ~select_n;

  // ---------------- System clock domain ----------------

  // Toggle synchronisers; stage one is read by stage two only.
  logic wr_meta, wr_sync, wr_seen;
  logic rd_meta, rd_sync, rd_seen;
  logic write_event, status_read_event;
  // Copy of the register file used by the framing logic.
  logic [7:0] shadow [LINES][8];
  // Violation flags and the last seen line conditions.
  logic [LINES-1:0] bpv_flag;
  logic [1:0] cond_prev [LINES];
  logic int_latch;
  logic next_int_set;
  // Synchronised system data inputs.
  logic bin_meta, bin_sync, din_meta, din_sync;
  // Frame position.
  logic bit_tick;
  logic [BIT_POS_W-1:0] bit_pos;
  logic [5:0] slot;
  logic [7:0] subslot;
  // Bytes captured from the system inputs per line.
  logic [7:0] b1_cap [LINES];
  logic [7:0] b2_cap [LINES];
  logic [1:0] d_cap [LINES];
  // Next values of the system outputs.
  logic next_b_hit, next_b_bit, next_d_hit, next_d_bit;

  qlc_frame_timer u_frame_timer (
    .clk(clk),
    .reset_n(reset_n),
    .clk_enable(clk_enable),
    .bit_clock(bit_clock),
    .frame_sync(frame_sync),
    .bit_tick(bit_tick),
    .bit_pos(bit_pos)
  );

  assign slot = bit_pos[8:3];
  assign subslot = bit_pos[8:1];

  // Bring the serial events and the system data pins into clk.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {wr_meta, wr_sync, wr_seen} <= 3'h0;
      {rd_meta, rd_sync, rd_seen} <= 3'h0;
      {bin_meta, bin_sync, din_meta, din_sync} <= 4'h0;
    end else if (clk_enable) begin
      wr_meta <= write_tgl;
      wr_sync <= wr_meta;
      wr_seen <= wr_sync;
      rd_meta <= status_rd_tgl;
      rd_sync <= rd_meta;
      rd_seen <= rd_sync;
      bin_meta <= b_data_in;
      bin_sync <= bin_meta;
      din_meta <= d_data_in;
      din_sync <= din_meta;
    end
  end

  assign write_event = wr_sync ^ wr_seen;
  assign status_read_event = rd_sync ^ rd_seen;

  // Copy the whole file after a write. The next write needs sixteen more
  // serial edges, far longer than the sync delay, so the copy is stable.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int l = 0; l < LINES; l++) begin
        for (int s = 0; s < 8; s++) begin
          shadow[l][s] <= (3'(s) == SEL_CTRL) ? CTRL_RESET : SLOT_RESET;
        end
      end
    end else if (clk_enable && write_event) begin
      shadow <= reg_file;
    end
  end

  // Status coding per line; a violation sticks until a status read or loss of sync, and a
  // violation in the clearing cycle survives it.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bpv_flag <= '0;
      status_q <= 8'h00;
    end else if (clk_enable) begin
      for (int l = 0; l < LINES; l++) begin
        if (line_in_sync[l] && line_bipolar_violation[l]) begin
          bpv_flag[l] <= 1'b1;
        end else if (status_read_event || !line_in_sync[l]) begin
          bpv_flag[l] <= 1'b0;
        end
        if (line_in_sync[l]) begin
          status_q[l*2 +: 2] <= {1'b1, ~bpv_flag[l]};
        end else begin
          status_q[l*2 +: 2] <= {1'b0, line_signal_detect[l]};
        end
      end
    end
  end

  // A change of sync or detect state on an enabled line raises the
  // interrupt; violations never do.
  always_comb begin
    next_int_set = 1'b0;
    for (int l = 0; l < LINES; l++) begin
      if (cond_prev[l] != {line_in_sync[l], line_signal_detect[l]} &&
          shadow[l][SEL_CTRL][CTRL_INT_ENABLE]) begin
        next_int_set = 1'b1;
      end
    end
  end

  // Interrupt latch: set wins over the clear from a status read.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_latch <= 1'b0;
      for (int l = 0; l < LINES; l++) begin
        cond_prev[l] <= 2'h0;
      end
    end else if (clk_enable) begin
      for (int l = 0; l < LINES; l++) begin
        cond_prev[l] <= {line_in_sync[l], line_signal_detect[l]};
      end
      if (next_int_set) begin
        int_latch <= 1'b1;
      end else if (status_read_event) begin
        int_latch <= 1'b0;
      end
    end
  end

  // Open-drain style: pulled low while latched, otherwise undriven.
  assign interrupt_n_out = 1'b0;
  assign interrupt_oe = int_latch;

  // Capture system input bits in the assigned transmit slots.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int l = 0; l < LINES; l++) begin
        b1_cap[l] <= IDLE_BYTE;
        b2_cap[l] <= IDLE_BYTE;
        d_cap[l] <= IDLE_BYTE[1:0];
      end
    end else if (clk_enable && bit_tick) begin
      for (int l = 0; l < LINES; l++) begin
        if (slot_hit(shadow[l][SEL_TX_B1], slot)) begin
          b1_cap[l][3'h7 - bit_pos[2:0]] <= bin_sync;
        end
        if (slot_hit(shadow[l][SEL_TX_B2], slot)) begin
          b2_cap[l][3'h7 - bit_pos[2:0]] <= bin_sync;
        end
        if (shadow[l][SEL_TX_D] == subslot) begin
          d_cap[l][1'b1 - bit_pos[0]] <= din_sync;
        end
      end
    end
  end

  // Pick what goes out on the B and D outputs in the current bit. Only an
  // activated line drives; digital loopback returns the captured bytes.
  always_comb begin
    next_b_hit = 1'b0;
    next_b_bit = 1'b1;
    next_d_hit = 1'b0;
    next_d_bit = 1'b1;
    for (int l = 0; l < LINES; l++) begin
      if (shadow[l][SEL_CTRL][CTRL_ACTIVATE]) begin
        if (slot_hit(shadow[l][SEL_RX_B1], slot)) begin
          next_b_hit = 1'b1;
          next_b_bit = shadow[l][SEL_CTRL][CTRL_DIGITAL_LOOP] ?
                       pick_bit(b1_cap[l], bit_pos[2:0]) :
                       pick_bit(line_rx_b1[l*8 +: 8], bit_pos[2:0]);
        end
        if (slot_hit(shadow[l][SEL_RX_B2], slot)) begin
          next_b_hit = 1'b1;
          next_b_bit = shadow[l][SEL_CTRL][CTRL_DIGITAL_LOOP] ?
                       pick_bit(b2_cap[l], bit_pos[2:0]) :
                       pick_bit(line_rx_b2[l*8 +: 8], bit_pos[2:0]);
        end
        if (shadow[l][SEL_RX_D] == subslot && !shadow[l][SEL_CTRL][CTRL_D_RX_BLOCK]) begin
          next_d_hit = 1'b1;
          next_d_bit = shadow[l][SEL_CTRL][CTRL_DIGITAL_LOOP] ?
                       d_cap[l][1'b1 - bit_pos[0]] :
                       line_rx_d[l*2 + 1 - int'(bit_pos[0])];
        end
      end
    end
  end

  // Register the system outputs at each bit; disabled slots stay undriven.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      b_data_out <= 1'b1;
      b_data_out_oe <= 1'b0;
      d_data_out <= 1'b1;
      d_data_out_oe <= 1'b0;
      rx_slot_active_n <= 1'b1;
    end else if (clk_enable && bit_tick) begin
      b_data_out <= next_b_bit;
      b_data_out_oe <= next_b_hit;
      d_data_out <= next_d_bit;
      d_data_out_oe <= next_d_hit;
      rx_slot_active_n <= ~next_b_hit;
    end
  end

  // Data toward each line. Loopbacks act only on an activated line; a
  // disabled transmit channel sends all ones.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_power_up <= '0;
      line_tx_b1 <= '1;
      line_tx_b2 <= '1;
      line_tx_d <= '1;
    end else if (clk_enable) begin
      for (int l = 0; l < LINES; l++) begin
        logic [7:0] c;
        c = shadow[l][SEL_CTRL];
        line_power_up[l] <= c[CTRL_ACTIVATE];
        if (c[CTRL_ACTIVATE] && (c[CTRL_LINE_LOOP] || c[CTRL_B1_LOOP])) begin
          line_tx_b1[l*8 +: 8] <= line_rx_b1[l*8 +: 8];
        end else begin
          line_tx_b1[l*8 +: 8] <= shadow[l][SEL_TX_B1][SLOT_ENABLE_BIT] ? b1_cap[l] : IDLE_BYTE;
        end
        if (c[CTRL_ACTIVATE] && (c[CTRL_LINE_LOOP] || c[CTRL_B2_LOOP])) begin
          line_tx_b2[l*8 +: 8] <= line_rx_b2[l*8 +: 8];
        end else begin
          line_tx_b2[l*8 +: 8] <= shadow[l][SEL_TX_B2][SLOT_ENABLE_BIT] ? b2_cap[l] : IDLE_BYTE;
        end
        if (c[CTRL_D_TX_BLOCK]) begin
          line_tx_d[l*2 +: 2] <= IDLE_BYTE[1:0];
        end else if (c[CTRL_ACTIVATE] && c[CTRL_LINE_LOOP]) begin
          line_tx_d[l*2 +: 2] <= line_rx_d[l*2 +: 2];
        end else begin
          line_tx_d[l*2 +: 2] <= d_cap[l];
        end
      end
    end
  end

endmodule : qlc_port

/* File: qlc_host.sv */
// Host model that drives the serial control port.
// Assumes the bench resolves the shared serial_out line into so_pin.
`timescale 1ns/10ps
module qlc_host (
  output logic serial_clock,
  output logic select_n,
  output logic serial_in,
  input wire logic so_pin
);
  // The serial clock stands still low and select stays high between frames.
  initial begin
    serial_clock = 1'b0;
    select_n = 1'b1;
    serial_in = 1'b1;
  end
  // Sends n bits of address then data; fewer than sixteen aborts the transfer.
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input int n, output logic [15:0] r);
    logic [15:0] w;
    w = {a, d};
    r = 16'h0000;
    select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      serial_in = w[15-i];
      #3 serial_clock = 1'b1;
      r = {r[14:0], so_pin};
      #3 serial_clock = 1'b0;
    end
    #3 select_n = 1'b1;
    serial_in = ~serial_in;
    #20;
  endtask : xfer
endmodule : qlc_host

/* File: qlc_port_properties.sv */
// Port checks of the quad line control port, sampled on clk.
// Assumes the serial clock is slow enough for clk to see every select edge.
`timescale 1ns/10ps
module qlc_port_properties
  import qlc_pkg::*;
#(
  parameter int LINES = NUM_LINES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic select_n,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic interrupt_n_out,
  input wire logic interrupt_oe,
  input wire logic b_data_out_oe,
  input wire logic rx_slot_active_n,
  input wire logic [LINES-1:0] line_signal_detect,
  input wire logic [LINES-1:0] line_in_sync,
  input wire logic [LINES-1:0] line_power_up
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Serial out stays low for the first three clk samples of the address phase.
  sequence s_first_byte;
    !serial_out [*3];
  endsequence
  property p_oe_off; select_n |-> !serial_out_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("serial out driven while deselected");
  property p_oe_on; !select_n |-> serial_out_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("serial out not driven while selected");
  property p_first_byte; $fell(select_n) |-> s_first_byte; endproperty
  a_first_byte: assert property (p_first_byte) else $error("first out byte not zero");
  property p_int_rise;
    $rose(interrupt_oe) |-> ($past(line_in_sync) != $past(line_in_sync, 2)) ||
      ($past(line_signal_detect) != $past(line_signal_detect, 2));
  endproperty
  a_int_rise: assert property (p_int_rise) else $error("interrupt without status change");
  property p_int_fall; $fell(interrupt_oe) |-> $past(select_n) == 1'b0; endproperty
  a_int_fall: assert property (p_int_fall) else $error("interrupt cleared without a read");
  property p_int_pin; interrupt_oe |-> !interrupt_n_out; endproperty
  a_int_pin: assert property (p_int_pin) else $error("interrupt pin not low");
  property p_reset; $rose(reset_n) |-> line_power_up == '0 && !interrupt_oe && rx_slot_active_n; endproperty
  a_reset: assert property (p_reset) else $error("outputs active after reset");
  property p_slot_flag; b_data_out_oe |-> !rx_slot_active_n; endproperty
  a_slot_flag: assert property (p_slot_flag) else $error("slot flag high while B out drives");
  property p_slot_live; $fell(rx_slot_active_n) |-> line_power_up != '0; endproperty
  a_slot_live: assert property (p_slot_live) else $error("slot flag on a powered down port");
endmodule : qlc_port_properties
bind qlc_port qlc_port_properties #(.LINES(LINES)) qlc_port_properties_i (.clk(clk), .reset_n(reset_n),
  .select_n(select_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe), .interrupt_n_out(interrupt_n_out),
  .interrupt_oe(interrupt_oe), .b_data_out_oe(b_data_out_oe), .rx_slot_active_n(rx_slot_active_n),
  .line_signal_detect(line_signal_detect), .line_in_sync(line_in_sync), .line_power_up(line_power_up));

/* File: qlc_port_tb.sv */
// Self-checking bench of the quad line control port.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module qlc_port_tb;
  import qlc_pkg::*;
  `define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
  logic clk, reset_n, serial_clock, select_n, serial_in, so_pin, bit_clock, frame_sync, run_tdm, b_data_in, d_data_in;
  logic serial_out, serial_out_oe, interrupt_n_out, interrupt_oe, b_data_out, b_data_out_oe;
  logic d_data_out, d_data_out_oe, rx_slot_active_n;
  logic [3:0] line_signal_detect, line_in_sync, line_bipolar_violation, line_power_up;
  logic [31:0] line_rx_b1, line_rx_b2, line_tx_b1, line_tx_b2;
  logic [7:0] line_rx_d, line_tx_d;
  logic [15:0] r;
  int error_cnt, compares, seed, cnt, mem[256]; // Model image indexed by even address.
  qlc_port qlc_port_i (.clk, .reset_n, .clk_enable(1'b1), .serial_clock, .select_n, .serial_in, .serial_out,
    .serial_out_oe, .interrupt_n_out, .interrupt_oe, .bit_clock, .frame_sync, .b_data_in, .b_data_out,
    .b_data_out_oe, .d_data_in, .d_data_out, .d_data_out_oe, .rx_slot_active_n, .line_signal_detect, .line_in_sync,
    .line_bipolar_violation, .line_rx_b1, .line_rx_b2, .line_rx_d, .line_power_up, .line_tx_b1, .line_tx_b2, .line_tx_d);
  qlc_host qlc_host_i (.serial_clock, .select_n, .serial_in, .so_pin);
  // The shared return line has a pull-up, so a released line reads high.
  assign so_pin = serial_out_oe ? serial_out : 1'b1;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // System data pins carry noise so the slot logic sees changing input.
  always @(negedge clk) {b_data_in, d_data_in} <= 2'($random(seed));
  // Bit clock and frame sync only run once the slot tests begin.
  initial begin
    bit_clock = 1'b0;
    frame_sync = 1'b0;
    wait (run_tdm);
    forever for (int b = 0; b < 512; b++) begin
      frame_sync = (b == 511);
      #122 bit_clock = 1'b1;
      #122 bit_clock = 1'b0;
    end
  end
  task automatic end_of_test;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // One whole transfer, compared with the model; mapped even addresses update it.
  task automatic acc(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] e;
    e = 8'(mem[a & 8'hfe]);
    qlc_host_i.xfer(a, d, 16, r);
    `CHK(r, {FIRST_OUT_BYTE, e})
    if (!a[0] && a < 8'h40 && a[3:1] != SEL_UNUSED) mem[a] = d;
  endtask : acc
  // Status inputs change on a falling edge and then settle.
  task automatic line_state(input logic [3:0] det, input logic [3:0] syn, input logic exp_int);
    @(negedge clk);
    line_signal_detect = det;
    line_in_sync = syn;
    repeat (3) @(negedge clk);
    `CHK(interrupt_oe, exp_int)
  endtask : line_state
  initial begin
    seed = 32'hf671;
    {reset_n, run_tdm, line_signal_detect, line_in_sync, line_bipolar_violation} = '0;
    line_rx_b1 = $random(seed);
    line_rx_b2 = $random(seed);
    line_rx_d = 8'($random(seed));
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    for (int l = 0; l < 4; l++) acc(8'(l * 16 + 15), 8'h00);
    for (int k = 0; k < 2; k++)
      for (int a = 0; a < 64; a++) acc(8'(a), 8'($random(seed)));
    repeat (5) @(negedge clk);
    for (int l = 0; l < 4; l++) `CHK(line_power_up[l], mem[l * 16 + 14][7])
    acc(8'h40, 8'h5a);
    acc(8'hce, 8'h33);
    acc(8'hcf, 8'h00);
    qlc_host_i.xfer(8'h0e, 8'h81, 15, r);
    acc(8'h0f, 8'h00);
    acc(8'h0e, 8'h80);
    acc(8'h1e, 8'h84);
    acc(8'h2e, 8'h80);
    acc(8'h3e, 8'ha2);
    repeat (5) @(negedge clk);
    `CHK({line_tx_b1[31:24], line_tx_b2[31:24]}, {line_rx_b1[31:24], line_rx_b2[31:24]})
    `CHK(line_tx_d[7:6], 2'h3)
    acc(8'h3e, 8'h18);
    repeat (5) @(negedge clk);
    `CHK({line_tx_b1[31:24], line_tx_b2[31:24]}, 16'hffff)
    acc(8'h3e, 8'h00);
    line_state(4'h2, 4'h2, 1'b1);
    mem[254] = 8'h0c;
    acc(8'hff, 8'h00);
    line_state(4'h2, 4'h2, 1'b0);
    @(negedge clk) line_bipolar_violation = 4'h2;
    @(negedge clk) line_bipolar_violation = 4'h0;
    line_state(4'h2, 4'h2, 1'b0);
    mem[254] = 8'h08;
    acc(8'hff, 8'h00);
    mem[254] = 8'h0c;
    acc(8'hff, 8'h00);
    line_state(4'h6, 4'h6, 1'b0);
    mem[254] = 8'h3c;
    acc(8'hff, 8'h00);
    acc(8'h1e, 8'h04);
    acc(8'h2e, 8'h00);
    acc(8'h0a, 8'h00);
    acc(8'h08, 8'h85);
    run_tdm = 1'b1;
    repeat (600) @(negedge bit_clock);
    for (int e = 0; e < 2; e++) begin
      cnt = 0;
      repeat (512) @(negedge bit_clock) if (rx_slot_active_n === 1'b0) begin
        `CHK(b_data_out, line_rx_b1[7 - cnt])
        cnt++;
      end
      `CHK(cnt, e ? 0 : 8)
      acc(8'h08, 8'h05);
      repeat (512) @(negedge bit_clock);
    end
    end_of_test();
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    #1000000;
    error_cnt++;
    end_of_test();
  end
endmodule : qlc_port_tb
